// [fzss_zone_select.sv]
`timescale 1ns/1ps
// Summary of operation
// - Read-only register holds hottest remote reading
// - First selector bits 7:4 choose fan A
// - First selector bits 3:0 choose fan B
// - Second selector bits 7:4 choose fan C
// - Second selector bits 3:0 choose fan D
// - Code zero selects the hottest reading
// - Code n selects reading n
// - Code ten selects reading ten
// - Both selectors reset to zero
module fzss_zone_select #(
	parameter int N_RD = fzss_pkg::NUM_READINGS,
	parameter int TW   = fzss_pkg::TEMP_W
) (
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic [7:0]              reg_addr,
	input  wire logic                    reg_wr_en,
	input  wire logic [7:0]              reg_wr_data,
	input  wire logic                    reg_rd_en,
	output logic      [7:0]              reg_rd_data,
	input  wire logic [N_RD-1:0][TW-1:0] temp_readings,
	output logic      [TW-1:0]           hottest_reading_field,
	output logic      [3:0]              fan_a_source_select,
	output logic      [3:0]              fan_b_source_select,
	output logic      [3:0]              fan_c_source_select,
	output logic      [3:0]              fan_d_source_select,
	output logic      [TW-1:0]           fan_a_temperature,
	output logic      [TW-1:0]           fan_b_temperature,
	output logic      [TW-1:0]           fan_c_temperature,
	output logic      [TW-1:0]           fan_d_temperature
);
	localparam int HALF_RD = N_RD / 2;

	logic [TW-1:0] hottest_reg;
	logic [TW-1:0] hottest_next;
	logic [TW-1:0] hottest_low;
	logic [TW-1:0] hottest_high;
	logic [3:0]    fan_a_sel_reg;
	logic [3:0]    fan_b_sel_reg;
	logic [3:0]    fan_c_sel_reg;
	logic [3:0]    fan_d_sel_reg;
	logic [7:0]    select_first_view;
	logic [7:0]    select_second_view;
	logic          first_wr_hit;
	logic          second_wr_hit;
	logic [3:0]    wr_high_field;
	logic [3:0]    wr_low_field;
	logic          rd_hit_hottest;
	logic          rd_hit_first;
	logic          rd_hit_second;
	logic          rd_hit_reading;
	logic [7:0]    rd_data_next;
	logic [3:0]    reading_idx;

	// Lower half of the readings; two half chains in parallel shorten the compare path
	always_comb begin
		hottest_low = temp_readings[0];
		for (int i = 1; i < HALF_RD; i++) begin
			if (temp_readings[i] > hottest_low) begin
				hottest_low = temp_readings[i];
			end
		end
	end

	// Upper half; readings come from this clock domain, so no synchroniser
	always_comb begin
		hottest_high = temp_readings[HALF_RD];
		for (int i = HALF_RD + 1; i < N_RD; i++) begin
			if (temp_readings[i] > hottest_high) begin
				hottest_high = temp_readings[i];
			end
		end
	end

	// Final pick; equal halves carry the same value, so the tie choice is free
	assign hottest_next = (hottest_high > hottest_low) ? hottest_high : hottest_low;

	// Hottest register is refreshed every cycle and has no write path
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hottest_reg <= fzss_pkg::HOTTEST_RESET;
		end else begin
			hottest_reg <= hottest_next;
		end
	end

	// Write address decode; any other offset, the hottest register too, is dropped
	assign first_wr_hit  = reg_wr_en && (reg_addr == fzss_pkg::REG_SELECT_FIRST_OFS);
	assign second_wr_hit = reg_wr_en && (reg_addr == fzss_pkg::REG_SELECT_SECOND_OFS);

	// Incoming byte split at the selector field boundary
	assign wr_high_field = reg_wr_data[fzss_pkg::SEL_HIGH_MSB:fzss_pkg::SEL_HIGH_LSB];
	assign wr_low_field  = reg_wr_data[fzss_pkg::SEL_LOW_MSB:fzss_pkg::SEL_LOW_LSB];

	// Fan A field; undefined codes are kept as written, only the mux treats them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fan_a_sel_reg <=
				fzss_pkg::SELECT_RESET[fzss_pkg::SEL_HIGH_MSB:fzss_pkg::SEL_HIGH_LSB];
		end else if (first_wr_hit) begin
			fan_a_sel_reg <= wr_high_field;
		end
	end

	// Fan B field, lower half of the first selector
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fan_b_sel_reg <=
				fzss_pkg::SELECT_RESET[fzss_pkg::SEL_LOW_MSB:fzss_pkg::SEL_LOW_LSB];
		end else if (first_wr_hit) begin
			fan_b_sel_reg <= wr_low_field;
		end
	end

	// Fan C field, upper half of the second selector
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fan_c_sel_reg <=
				fzss_pkg::SELECT_RESET[fzss_pkg::SEL_HIGH_MSB:fzss_pkg::SEL_HIGH_LSB];
		end else if (second_wr_hit) begin
			fan_c_sel_reg <= wr_high_field;
		end
	end

	// Fan D field, lower half of the second selector
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fan_d_sel_reg <=
				fzss_pkg::SELECT_RESET[fzss_pkg::SEL_LOW_MSB:fzss_pkg::SEL_LOW_LSB];
		end else if (second_wr_hit) begin
			fan_d_sel_reg <= wr_low_field;
		end
	end

	// Byte view of the first selector for read-back, fields at their set positions
	always_comb begin
		select_first_view = 8'h00;
		select_first_view[fzss_pkg::SEL_HIGH_MSB:fzss_pkg::SEL_HIGH_LSB] = fan_a_sel_reg;
		select_first_view[fzss_pkg::SEL_LOW_MSB:fzss_pkg::SEL_LOW_LSB]   = fan_b_sel_reg;
	end

	// Byte view of the second selector
	always_comb begin
		select_second_view = 8'h00;
		select_second_view[fzss_pkg::SEL_HIGH_MSB:fzss_pkg::SEL_HIGH_LSB] = fan_c_sel_reg;
		select_second_view[fzss_pkg::SEL_LOW_MSB:fzss_pkg::SEL_LOW_LSB]   = fan_d_sel_reg;
	end

	// Selector fields and the hottest value leave straight from their flip-flops
	assign fan_a_source_select   = fan_a_sel_reg;
	assign fan_b_source_select   = fan_b_sel_reg;
	assign fan_c_source_select   = fan_c_sel_reg;
	assign fan_d_source_select   = fan_d_sel_reg;
	assign hottest_reading_field = hottest_reg;

	// Read address decode; reading mirrors let software see what each code routes
	assign rd_hit_hottest = (reg_addr == fzss_pkg::REG_HOTTEST_OFS);
	assign rd_hit_first   = (reg_addr == fzss_pkg::REG_SELECT_FIRST_OFS);
	assign rd_hit_second  = (reg_addr == fzss_pkg::REG_SELECT_SECOND_OFS);
	assign rd_hit_reading = (reg_addr >= fzss_pkg::REG_READING_BASE_OFS) &&
		(reg_addr <= fzss_pkg::REG_READING_LAST_OFS);
	assign reading_idx    = 4'(reg_addr - fzss_pkg::REG_READING_BASE_OFS);

	// Read multiplexer; unmapped offsets return a fixed value rather than stale data
	always_comb begin
		rd_data_next = fzss_pkg::UNMAPPED_RD_VAL;
		if (rd_hit_hottest) begin
			rd_data_next = 8'(hottest_reg);
		end else if (rd_hit_first) begin
			rd_data_next = select_first_view;
		end else if (rd_hit_second) begin
			rd_data_next = select_second_view;
		end else if (rd_hit_reading) begin
			rd_data_next = 8'(temp_readings[reading_idx]);
		end
	end

	// Read data held until the next read so the serial engine can shift it out
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rd_data <= fzss_pkg::RD_DATA_RESET;
		end else if (reg_rd_en) begin
			reg_rd_data <= rd_data_next;
		end
	end

	// Fan A source mux; each fan gets its own copy so the fans never share a path
	fzss_src_mux #(.N_RD(N_RD), .TW(TW)) u_mux_a (
		.clk      (clk),
		.arst_n   (arst_n),
		.sel      (fan_a_source_select),
		.readings (temp_readings),
		.hottest  (hottest_reg),
		.fan_temp (fan_a_temperature)
	);

	// Fan B source mux
	fzss_src_mux #(.N_RD(N_RD), .TW(TW)) u_mux_b (
		.clk      (clk),
		.arst_n   (arst_n),
		.sel      (fan_b_source_select),
		.readings (temp_readings),
		.hottest  (hottest_reg),
		.fan_temp (fan_b_temperature)
	);

	// Fan C source mux
	fzss_src_mux #(.N_RD(N_RD), .TW(TW)) u_mux_c (
		.clk      (clk),
		.arst_n   (arst_n),
		.sel      (fan_c_source_select),
		.readings (temp_readings),
		.hottest  (hottest_reg),
		.fan_temp (fan_c_temperature)
	);

	// Fan D source mux
	fzss_src_mux #(.N_RD(N_RD), .TW(TW)) u_mux_d (
		.clk      (clk),
		.arst_n   (arst_n),
		.sel      (fan_d_source_select),
		.readings (temp_readings),
		.hottest  (hottest_reg),
		.fan_temp (fan_d_temperature)
	);
endmodule

// [fzss_pkg.sv]
package fzss_pkg;
	// Register offsets on the device's internal register port
	localparam logic [7:0] REG_READING_BASE_OFS  = 8'h20;
	localparam logic [7:0] REG_READING_LAST_OFS  = 8'h29;
	localparam logic [7:0] REG_HOTTEST_OFS       = 8'h78;
	localparam logic [7:0] REG_SELECT_FIRST_OFS  = 8'h7C;
	localparam logic [7:0] REG_SELECT_SECOND_OFS = 8'h7D;

	// Field positions inside the selector registers
	localparam int SEL_HIGH_MSB = 7;
	localparam int SEL_HIGH_LSB = 4;
	localparam int SEL_LOW_MSB  = 3;
	localparam int SEL_LOW_LSB  = 0;

	// Reset values
	localparam logic [7:0] HOTTEST_RESET   = 8'h00;
	localparam logic [7:0] SELECT_RESET    = 8'h00;
	localparam logic [7:0] RD_DATA_RESET   = 8'h00;
	localparam logic [7:0] UNMAPPED_RD_VAL = 8'h00;

	// Selector codes
	localparam logic [3:0] SEL_CODE_HOTTEST = 4'h0;
	localparam logic [3:0] SEL_CODE_FIRST   = 4'h1;
	localparam logic [3:0] SEL_CODE_LAST    = 4'hA;

	// Number of remote readings and their width
	localparam int NUM_READINGS = 10;
	localparam int TEMP_W       = 8;
endpackage

// [fzss_src_mux.sv]
`timescale 1ns/1ps
// One fan's source choice: hottest reading or reading n, registered out
module fzss_src_mux #(
	parameter int N_RD = fzss_pkg::NUM_READINGS,
	parameter int TW   = fzss_pkg::TEMP_W
) (
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic [3:0]              sel,
	input  wire logic [N_RD-1:0][TW-1:0] readings,
	input  wire logic [TW-1:0]           hottest,
	output logic      [TW-1:0]           fan_temp
);
	logic [TW-1:0] fan_temp_next;

	// Code 0 and the undefined codes above the last reading follow the hottest
	always_comb begin
		fan_temp_next = hottest;
		if (sel >= fzss_pkg::SEL_CODE_FIRST && sel <= fzss_pkg::SEL_CODE_LAST) begin
			fan_temp_next = readings[sel - fzss_pkg::SEL_CODE_FIRST];
		end
	end

	// Registered so the fan loop sees a glitch-free value
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fan_temp <= TW'(fzss_pkg::HOTTEST_RESET);
		end else begin
			fan_temp <= fan_temp_next;
		end
	end
endmodule

// [fzss_zone_select_properties.sv]
`timescale 1ns/1ps
// Watches selector writes, reset and the fan A and fan B routing at the top ports
module fzss_zone_select_chk (
	input wire logic	clk,
	input wire logic	arst_n,
	input wire logic [7:0]	reg_addr,
	input wire logic	reg_wr_en,
	input wire logic [7:0]	reg_wr_data,
	input wire logic [9:0][7:0]	temp_readings,
	input wire logic [7:0]	hottest_reading_field,
	input wire logic [3:0]	fan_a_source_select,
	input wire logic [3:0]	fan_b_source_select,
	input wire logic [3:0]	fan_c_source_select,
	input wire logic [3:0]	fan_d_source_select,
	input wire logic [7:0]	fan_a_temperature,
	input wire logic [7:0]	fan_b_temperature
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Field placement inside the two selector registers
	property p_wr_a;
		reg_wr_en && reg_addr == 8'h7C |=> fan_a_source_select == $past(reg_wr_data[7:4]);
	endproperty
	a_wr_a: assert property (p_wr_a) else $error("fan a select");
	property p_wr_b;
		reg_wr_en && reg_addr == 8'h7C |=> fan_b_source_select == $past(reg_wr_data[3:0]);
	endproperty
	a_wr_b: assert property (p_wr_b) else $error("fan b select");
	property p_wr_c;
		reg_wr_en && reg_addr == 8'h7D |=> fan_c_source_select == $past(reg_wr_data[7:4]);
	endproperty
	a_wr_c: assert property (p_wr_c) else $error("fan c select");
	property p_wr_d;
		reg_wr_en && reg_addr == 8'h7D |=> fan_d_source_select == $past(reg_wr_data[3:0]);
	endproperty
	a_wr_d: assert property (p_wr_d) else $error("fan d select");
	// Reset is watched while active, so it carries its own never-true disable in place of the default
	property p_rst;
		disable iff (1'b0) !arst_n |-> {fan_a_source_select, fan_b_source_select,
			fan_c_source_select, fan_d_source_select} == 16'h0000;
	endproperty
	a_rst: assert property (p_rst) else $error("select reset");
	// Routing lags the selector by one register stage
	property p_hot;
		$past(fan_a_source_select) == 4'h0 |->
			fan_a_temperature == $past(hottest_reading_field);
	endproperty
	a_hot: assert property (p_hot) else $error("code zero route");
	property p_undef;
		$past(fan_a_source_select) > 4'hA |->
			fan_a_temperature == $past(hottest_reading_field);
	endproperty
	a_undef: assert property (p_undef) else $error("undefined code route");
	property p_num;
		$past(fan_a_source_select) inside {[4'h1:4'h9]} |->
			fan_a_temperature == $past(temp_readings[fan_a_source_select - 4'h1]);
	endproperty
	a_num: assert property (p_num) else $error("reading route");
	property p_last;
		$past(fan_b_source_select) == 4'hA |->
			fan_b_temperature == $past(temp_readings[9]);
	endproperty
	a_last: assert property (p_last) else $error("reading ten route");
endmodule

// [tb.sv]
`timescale 1ns/1ps
bind fzss_zone_select fzss_zone_select_chk u_chk (
	.clk                   (clk),
	.arst_n                (arst_n),
	.reg_addr              (reg_addr),
	.reg_wr_en             (reg_wr_en),
	.reg_wr_data           (reg_wr_data),
	.temp_readings         (temp_readings),
	.hottest_reading_field (hottest_reading_field),
	.fan_a_source_select   (fan_a_source_select),
	.fan_b_source_select   (fan_b_source_select),
	.fan_c_source_select   (fan_c_source_select),
	.fan_d_source_select   (fan_d_source_select),
	.fan_a_temperature     (fan_a_temperature),
	.fan_b_temperature     (fan_b_temperature)
);
module tb;
	logic	clk = 1'b0;
	logic	arst_n = 1'b1;
	logic [7:0]	reg_addr = 8'h00;
	logic	reg_wr_en = 1'b0;
	logic [7:0]	reg_wr_data = 8'h00;
	logic	reg_rd_en = 1'b0;
	logic [9:0][7:0]	temp_readings = '0;
	logic [7:0]	reg_rd_data, hottest_reading_field;
	logic [7:0]	fan_a_temperature, fan_b_temperature, fan_c_temperature, fan_d_temperature;
	logic [3:0]	fan_a_source_select, fan_b_source_select, fan_c_source_select, fan_d_source_select;
	int	error_cnt = 0;
	int	total_checks = 0;
	// 125 MHz clock
	always #4 clk = ~clk;
	fzss_zone_select u_dut (
		.clk                   (clk),
		.arst_n                (arst_n),
		.reg_addr              (reg_addr),
		.reg_wr_en             (reg_wr_en),
		.reg_wr_data           (reg_wr_data),
		.reg_rd_en             (reg_rd_en),
		.reg_rd_data           (reg_rd_data),
		.temp_readings         (temp_readings),
		.hottest_reading_field (hottest_reading_field),
		.fan_a_source_select   (fan_a_source_select),
		.fan_b_source_select   (fan_b_source_select),
		.fan_c_source_select   (fan_c_source_select),
		.fan_d_source_select   (fan_d_source_select),
		.fan_a_temperature     (fan_a_temperature),
		.fan_b_temperature     (fan_b_temperature),
		.fan_c_temperature     (fan_c_temperature),
		.fan_d_temperature     (fan_d_temperature)
	);
	// Expected source: readings by code 1 to 10, the hottest otherwise
	function automatic logic [7:0] mx();
		mx = 8'h00;
		for (int i = 0; i < 10; i++) if (temp_readings[i] > mx) mx = temp_readings[i];
	endfunction
	function automatic logic [7:0] ex(input logic [3:0] c);
		return (c >= 4'h1 && c <= 4'hA) ? temp_readings[c - 4'h1] : mx();
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Strobes rise and fall on falling edges, one cycle each
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		chk(reg_rd_data, e);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// All codes on every fan, with fresh readings each time
	initial begin
		void'($urandom(32'hBCC8777A));
		// Reset falls on a real edge so the asynchronous branch fires
		@(negedge clk);
		arst_n = 1'b0;
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		rd(8'h7C, 8'h00);
		$display("test reset done");
		for (int c = 0; c < 16; c++) begin
			for (int i = 0; i < 10; i++) temp_readings[i] = 8'($urandom);
			if (c == 5) temp_readings = '1;
			wr(8'h7C, {4'(c), ~4'(c)});
			wr(8'h7D, {~4'(c), 4'(c)});
			repeat (2) @(negedge clk);
			chk(fan_a_temperature, ex(4'(c)));
			chk(fan_b_temperature, ex(~4'(c)));
			chk(fan_c_temperature, ex(~4'(c)));
			chk(fan_d_temperature, ex(4'(c)));
			chk(hottest_reading_field, mx());
			rd(8'h7D, {~4'(c), 4'(c)});
		end
		$display("test routing done");
		for (int i = 0; i < 10; i++) rd(8'h20 + 8'(i), temp_readings[i]);
		wr(8'h78, 8'h5A);
		rd(8'h78, mx());
		rd(8'h55, 8'h00);
		arst_n = 1'b0;
		@(negedge clk);
		chk({fan_a_source_select, fan_d_source_select}, 8'h00);
		arst_n = 1'b1;
		rd(8'h7D, 8'h00);
		$display("test access done");
		end_of_test();
	end
endmodule
